// ---- common/dmh_pkg.sv ----
// Constants for the dot-matrix display host port.
// Assumes a single 40 MHz core clock; all numbers live here.
package dmh_pkg;
  // ==========================================================
  // Section decode on the two upper address lines
  localparam logic [1:0] SEL_POINTER   = 2'h0;
  localparam logic [1:0] SEL_GLYPH_ROW = 2'h1;
  localparam logic [1:0] SEL_CONTROL   = 2'h2;
  localparam logic [1:0] SEL_CHARACTER = 2'h3;
  // ==========================================================
  // Sizes and field positions
  localparam int          NUM_POSITIONS  = 8;
  localparam int          NUM_GLYPHS     = 16;
  localparam int          NUM_ROWS       = 8;
  localparam int          TYPE_FLAG_BIT  = 7;
  localparam int          FLASH_EN_BIT   = 3;
  localparam int          FLASH_DATA_BIT = 0;
  localparam logic [7:0]  CHAR_RESET     = 8'h20;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  POINTER_RESET  = 8'h00;
  // ==========================================================
  // Timing
  localparam int          FLASH_DIVIDE   = 28672;
  localparam int          OSC_DIVIDE     = 700;
  localparam int          RESET_WAIT_PULSES = 3;
endpackage

// ---- design/dmh_host_port.sv ----
// Parallel host port of an eight-position 5x7 dot-matrix display.
// Host pins arrive asynchronously and are synchronised to ref_clk_i.
// The host keeps ce low per access and returns it high between accesses.
//
// Notes on behaviour
// - Flash-select low hits flash store only
// - Upper address picks pointer, rows, control, chars
// - Low address picks position or glyph row
// - Clock source select: 1 internal, 0 external
// - Internal mode drives clock pin out
// - Write when write strobe and enable low
// - Read drives data when read and enable low
// - Character bit 7 selects ASCII or glyph
// - Pointer is 8 bits, low four used
// - Row store addressed by pointer and row
// - Row bit 0 rightmost, bit 4 leftmost
// - Flash store one bit from data bit 0
// - Flash needs control bit 3, clock/28672
`timescale 1ns/1ps
module dmh_host_port
  import dmh_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       attribute_store_select_n_i,
  input  wire logic [4:0] addr_i,
  input  wire logic       ce_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  input  wire logic       clock_source_select_i,
  input  wire logic       clk_pin_i,
  output logic            clk_pin_o,
  output logic            clk_pin_oe_o,
  input  wire logic [2:0] scan_pos_i,
  input  wire logic [2:0] scan_row_i,
  output logic            scan_is_glyph_o,
  output logic      [6:0] scan_ascii_o,
  output logic      [4:0] scan_dots_o,
  output logic            scan_visible_o,
  output logic      [7:0] control_word_o
);
  // ==========================================================
  // Pin synchronisers
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  logic [7:0] data_meta;
  logic [7:0] data_sync;
  logic [1:0] clk_pin_meta;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_meta  <= 10'h3FF;
      pin_sync  <= 10'h3FF;
      data_meta <= 8'h00;
      data_sync <= 8'h00;
      clk_pin_meta <= 2'h0;
    end
    else
    begin
      pin_meta  <= {attribute_store_select_n_i, addr_i, ce_n_i, wr_n_i,
                    rd_n_i, clock_source_select_i};
      pin_sync  <= pin_meta;
      data_meta <= data_i;
      data_sync <= data_meta;
      clk_pin_meta <= {clk_pin_meta[0], clk_pin_i};
    end
  end

  logic       attr_sel_n;
  logic [4:0] addr;
  logic       ce_n;
  logic       wr_n;
  logic       rd_n;
  logic       clk_int;
  assign attr_sel_n = pin_sync[9];
  assign addr       = pin_sync[8:4];
  assign ce_n       = pin_sync[3];
  assign wr_n       = pin_sync[2];
  assign rd_n       = pin_sync[1];
  assign clk_int    = pin_sync[0];

  // ==========================================================
  // Access decode
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_DONE = 3'b010,
    ST_WAIT = 3'b100
  } dmh_state_t;
  dmh_state_t state;
  dmh_state_t next_state;

  logic [2:0] pos;
  logic       sel_flash;
  logic       sel_ptr;
  logic       sel_row;
  logic       sel_ctrl;
  logic       sel_char;
  logic       wr_active;
  logic       wr_fire;
  assign pos       = addr[2:0];
  assign sel_flash = !attr_sel_n;
  assign sel_ptr   = attr_sel_n && addr[4:3] == SEL_POINTER;
  assign sel_row   = attr_sel_n && addr[4:3] == SEL_GLYPH_ROW;
  assign sel_ctrl  = attr_sel_n && addr[4:3] == SEL_CONTROL;
  assign sel_char  = attr_sel_n && addr[4:3] == SEL_CHARACTER;
  assign wr_active = !ce_n && !wr_n && rd_n;
  // One store per enable window; the host re-arms by raising ce
  assign wr_fire   = wr_active && state == ST_IDLE;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (wr_active) next_state = ST_DONE;
      ST_DONE: next_state = ST_WAIT;
      ST_WAIT: if (ce_n) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ==========================================================
  // Storage
  logic [7:0]   char_store [NUM_POSITIONS];
  logic [NUM_POSITIONS-1:0] flash_store;
  logic [4:0]   glyph_row_store [NUM_GLYPHS*NUM_ROWS];
  logic [7:0]   glyph_pointer;
  logic [7:0]   control_word;
  logic [6:0]   row_index;
  assign row_index = {glyph_pointer[3:0], pos};

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NUM_POSITIONS; i++)
        char_store[i] <= CHAR_RESET;
      flash_store  <= '0;
      control_word <= CTRL_RESET;
    end
    else if (wr_fire)
    begin
      if (sel_char)
        char_store[pos] <= data_sync;
      if (sel_flash)
        flash_store[pos] <= data_sync[FLASH_DATA_BIT];
      if (sel_ctrl)
        control_word <= data_sync;
    end
  end

  // Pointer and glyph rows survive reset, as the display keeps them
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_fire && sel_ptr)
      glyph_pointer <= data_sync;
    if (wr_fire && sel_row)
      glyph_row_store[row_index] <= data_sync[4:0];
  end

  // ==========================================================
  // Read path
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end
    else
    begin
      data_oe_o <= !ce_n && !rd_n && wr_n;
      if (sel_flash)
        data_o <= {7'h00, flash_store[pos]};
      else if (sel_ptr)
        data_o <= glyph_pointer;
      else if (sel_row)
        data_o <= {3'h0, glyph_row_store[row_index]};
      else if (sel_ctrl)
        data_o <= control_word;
      else
        data_o <= char_store[pos];
    end
  end

  // ==========================================================
  // Clock source and flash timebase
  logic [9:0]  osc_count;
  logic        osc_clk;
  logic        ext_prev;
  logic        tick;
  logic [14:0] flash_count;
  logic        flash_phase;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      osc_count <= 10'h000;
      osc_clk   <= 1'b0;
      ext_prev  <= 1'b0;
    end
    else
    begin
      ext_prev <= clk_pin_meta[1];
      if (osc_count == 10'(OSC_DIVIDE - 1))
      begin
        osc_count <= 10'h000;
        osc_clk   <= !osc_clk;
      end
      else
        osc_count <= osc_count + 10'h001;
    end
  end

  // Internal oscillator edges or external pin edges drive the timebase
  assign tick = clk_int ? (osc_count == 10'(OSC_DIVIDE - 1) && !osc_clk)
                        : (clk_pin_meta[1] && !ext_prev);
  assign clk_pin_o    = osc_clk;
  assign clk_pin_oe_o = clk_int;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      flash_count <= 15'h0000;
      flash_phase <= 1'b0;
    end
    else if (tick)
    begin
      if (flash_count == 15'(FLASH_DIVIDE / 2 - 1))
      begin
        flash_count <= 15'h0000;
        flash_phase <= !flash_phase;
      end
      else
        flash_count <= flash_count + 15'h0001;
    end
  end

  // ==========================================================
  // Refresh lookup, position 0 is the leftmost cell
  logic [7:0] scan_char;
  logic [4:0] scan_glyph_row;
  assign scan_char      = char_store[scan_pos_i];
  assign scan_glyph_row = glyph_row_store[{scan_char[3:0], scan_row_i}];

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scan_is_glyph_o <= 1'b0;
      scan_ascii_o    <= 7'h00;
      scan_dots_o     <= 5'h00;
      scan_visible_o  <= 1'b1;
      control_word_o  <= CTRL_RESET;
    end
    else
    begin
      scan_is_glyph_o <= scan_char[TYPE_FLAG_BIT];
      scan_ascii_o    <= scan_char[6:0];
      // Bit 4 feeds the leftmost column, bit 0 the rightmost
      scan_dots_o     <= scan_glyph_row;
      scan_visible_o  <= !(control_word[FLASH_EN_BIT]
                           && flash_store[scan_pos_i]
                           && flash_phase);
      control_word_o  <= control_word;
    end
  end

  // ==========================================================
  // Checks
  a_flash_only_low:
    assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !attr_sel_n |-> !(sel_char || sel_ctrl || sel_ptr || sel_row))
    else $error("flash select low reached another store");
  a_write_stores_char:
    assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (wr_fire && sel_char) |=> char_store[$past(pos)] == $past(data_sync))
    else $error("character write not stored");
  a_read_drives_bus:
    assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (!ce_n && !rd_n && wr_n) |=> data_oe_o)
    else $error("read did not drive the data bus");
  a_idle_bus_released:
    assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      ce_n |=> !data_oe_o)
    else $error("data bus driven without enable");
  a_clock_pin_dir:
    assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      clk_pin_oe_o == clk_int)
    else $error("clock pin direction wrong");
  a_flash_bit_store:
    assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (wr_fire && sel_flash) |=>
        flash_store[$past(pos)] == $past(data_sync[0]))
    else $error("flash attribute not stored");
  a_no_flash_off:
    assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !control_word[FLASH_EN_BIT] |=> scan_visible_o)
    else $error("character blanked with flash disabled");
  a_single_write:
    assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_fire |=> !wr_fire [*2])
    else $error("second store in one enable window");
  a_glyph_flag:
    assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      1'b1 |=> scan_is_glyph_o == $past(scan_char[TYPE_FLAG_BIT]))
    else $error("type flag not passed to refresh");
endmodule

// ---- verif/dmh_host_model.sv ----
// Host microprocessor model: strobe-qualified byte reads and writes.
// Assumes the device synchronises its pins to ref_clk_i.
`timescale 1ns/1ps
module dmh_host_model
(
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] data_o,
  input  wire logic       data_oe_o,
  output logic            attribute_store_select_n_o,
  output logic      [4:0] addr_o,
  output logic            ce_n_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic      [7:0] data_wr_o
);
  initial
  begin
    attribute_store_select_n_o = 1'b1;
    addr_o    = 5'h00;
    ce_n_o    = 1'b1;
    wr_n_o    = 1'b1;
    rd_n_o    = 1'b1;
    data_wr_o = 8'h00;
  end

  // ==========================================================
  // One access; address and strobes held while enable is low
  task automatic access(input logic attr_sel_n, input logic [4:0] a,
                        input logic wr, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    q = 8'hXX;
    n = 0;
    @(posedge ref_clk_i);
    attribute_store_select_n_o <= attr_sel_n;
    addr_o    <= a;
    ce_n_o    <= 1'b0;
    wr_n_o    <= ~wr;
    rd_n_o    <= wr;
    data_wr_o <= wr ? d : ~data_wr_o;
    if (wr)
    begin
      repeat (4) @(posedge ref_clk_i);
    end
    else
    begin
      // Sampled mid-cycle, where the registered answer is settled
      do
      begin
        @(negedge ref_clk_i);
        n++;
      end
      while (data_oe_o !== 1'b1 && n < 8);
      if (data_oe_o === 1'b1)
        q = data_o;
      @(posedge ref_clk_i);
    end
    ce_n_o    <= 1'b1;
    wr_n_o    <= 1'b1;
    rd_n_o    <= 1'b1;
    data_wr_o <= ~data_wr_o;
    // Recovery covers the two sync flops plus one edge
    repeat (4) @(posedge ref_clk_i);
  endtask
endmodule

// ---- verif/dot_matrix_display_host_port_tb.sv ----
// Self-checking bench for the display host port.
// Assumes dmh_pkg and the host model are compiled first.
`timescale 1ns/1ps
module dot_matrix_display_host_port_tb
  import dmh_pkg::*;
;
  logic       ref_clk_i;
  logic       reset_n_i;
  logic       attr_sel_n;
  logic [4:0] addr;
  logic       ce_n;
  logic       wr_n;
  logic       rd_n;
  logic [7:0] din;
  logic [7:0] dout;
  logic       doe;
  logic       clk_sel;
  logic       ext_clk = 1'b0;
  logic       ext_run;
  logic       ck_o;
  logic       ck_oe;
  logic [2:0] spos;
  logic [2:0] srow;
  logic       s_glyph;
  logic [6:0] s_ascii;
  logic [4:0] s_dots;
  logic       s_vis;
  logic [7:0] ctrl;
  logic [7:0] q;
  logic [4:0] rows [7] = '{5'h1F, 5'h10, 5'h10, 5'h1E, 5'h10, 5'h10, 5'h10};
  int         num_errors = 0;
  int         checked = 0;
  int         flips;
  int         wait_n;

  dmh_host_model u_host (.ref_clk_i(ref_clk_i), .data_o(dout),
    .data_oe_o(doe), .attribute_store_select_n_o(attr_sel_n), .addr_o(addr),
    .ce_n_o(ce_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .data_wr_o(din));

  dmh_host_port u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .attribute_store_select_n_i(attr_sel_n), .addr_i(addr), .ce_n_i(ce_n),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .data_i(din), .data_o(dout),
    .data_oe_o(doe), .clock_source_select_i(clk_sel), .clk_pin_i(ext_clk),
    .clk_pin_o(ck_o), .clk_pin_oe_o(ck_oe), .scan_pos_i(spos),
    .scan_row_i(srow), .scan_is_glyph_o(s_glyph), .scan_ascii_o(s_ascii),
    .scan_dots_o(s_dots), .scan_visible_o(s_vis), .control_word_o(ctrl));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // Clock for slave mode: one external period per two reference cycles
  always @(posedge ref_clk_i)
    ext_clk <= ext_run ? !ext_clk : 1'b0;

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic f, input logic [4:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_host.access(f, a, 1'b1, d, unused);
  endtask

  task automatic rd(input logic f, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] got;
    u_host.access(f, a, 1'b0, 8'h00, got);
    check(got, e);
  endtask

  task automatic scan(input logic [2:0] p, input logic [2:0] r);
    @(posedge ref_clk_i);
    spos <= p;
    srow <= r;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Run needs about 32000 cycles; the limit leaves wide margin
  initial
  begin
    #(25 * 80000);
    num_errors++;
    print_verdict();
  end

  // ==========================================================
  // Tests
  initial
  begin
    reset_n_i = 1'b0;
    clk_sel = 1'b1;
    ext_run = 1'b0;
    spos = 3'h0;
    srow = 3'h0;
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(1'b1, {SEL_CHARACTER, 3'h0}, CHAR_RESET);
    rd(1'b0, 5'h1F, 8'h00);
    rd(1'b1, {SEL_CONTROL, 3'h5}, CTRL_RESET);
    for (int i = 0; i < 8; i++)
      wr(1'b1, {SEL_CHARACTER, 3'(i)}, (i == 7) ? 8'h85 : 8'(8'h41 + i));
    for (int i = 0; i < 8; i++)
    begin
      q = (i == 7) ? 8'h85 : 8'(8'h41 + i);
      rd(1'b1, {SEL_CHARACTER, 3'(i)}, q);
    end
    for (int i = 0; i < 7; i++)
    begin
      scan(3'(i), 3'h0);
      check({1'b0, s_ascii}, 8'(8'h41 + i));
      check({7'h00, s_glyph}, 8'h00);
    end
    wr(1'b0, {SEL_CHARACTER, 3'h2}, 8'hFE);
    rd(1'b0, {SEL_GLYPH_ROW, 3'h2}, 8'h00);
    wr(1'b0, {SEL_POINTER, 3'h2}, 8'h01);
    rd(1'b0, {SEL_CONTROL, 3'h2}, 8'h01);
    rd(1'b1, {SEL_CHARACTER, 3'h2}, 8'h43);
    scan(3'h2, 3'h0);
    check({7'h00, s_vis}, 8'h01);
    wr(1'b1, {SEL_POINTER, 3'h6}, 8'hF5);
    rd(1'b1, {SEL_POINTER, 3'h1}, 8'hF5);
    for (int r = 0; r < 7; r++)
      wr(1'b1, {SEL_GLYPH_ROW, 3'(r)}, {3'h7, rows[r]});
    for (int r = 0; r < 7; r++)
    begin
      rd(1'b1, {SEL_GLYPH_ROW, 3'(r)}, {3'h0, rows[r]});
      scan(3'h7, 3'(r));
      check({3'h0, s_dots}, {3'h0, rows[r]});
      check({7'h00, s_glyph}, 8'h01);
    end
    wr(1'b1, {SEL_CONTROL, 3'h0}, 8'h08);
    rd(1'b1, {SEL_CONTROL, 3'h7}, 8'h08);
    check(ctrl, 8'h08);
    check({7'h00, ck_oe}, 8'h01);
    flips = 0;
    for (int c = 0; c < 1600; c++)
    begin
      q[0] = ck_o;
      @(negedge ref_clk_i);
      if (ck_o !== q[0])
        flips++;
    end
    check({7'h00, flips > 0}, 8'h01);
    @(posedge ref_clk_i);
    clk_sel <= 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check({7'h00, ck_oe}, 8'h00);
    // Half a flash period is 14336 external clocks; at two reference
    // cycles per external clock that spans FLASH_DIVIDE cycles
    ext_run <= 1'b1;
    scan(3'h2, 3'h0);
    wait_n = 0;
    while (s_vis === 1'b1 && wait_n < FLASH_DIVIDE + 64)
    begin
      @(negedge ref_clk_i);
      wait_n++;
    end
    check({7'h00, s_vis}, 8'h00);
    q[0] = wait_n > FLASH_DIVIDE - 64 && wait_n < FLASH_DIVIDE + 64;
    check({7'h00, q[0]}, 8'h01);
    print_verdict();
  end
endmodule
